// >>> rtl/pdma_channel.sv
// peripheral dma controller: channel set, apb registers, transfer engine
// assumes peripherals and bus matrix share the clock; apb master on clock
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// What this block does
// - nineteen channels: nine pairs plus one bidirectional
// - single channel: pointer, count, next pointer, next count
// - bidirectional channel has tx and rx register views
// - count reads return transfers still remaining
// - enable and disable bits; status shows enabled
// - pointer advances by one, two or four
// - rewritten pointer used for following accesses
// - current count drops per moved item
// - both counts zero: stop, raise end flag
// - next nonzero: reload current, zero next, continue
// - rx ready: bus, read holding, buffer, memory
// - tx ready: bus, read memory, write holding
// - rx end set at zero; nonzero count clears
// - tx end set at zero; nonzero count clears
// - rx full when both counts zero
// - tx empty when both counts zero
// - half duplex flags come from one channel
// - zero count stops, nonzero starts if enabled
// - half duplex rx and tx views share storage
module pdma_channel #(
    parameter int NUM_PERIPH = pdma_pkg::NUM_PERIPH
) (
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [pdma_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire logic [NUM_PERIPH-1:0]       rxReady,
    input  wire logic [NUM_PERIPH-1:0]       txReady,
    input  wire pdma_pkg::pdma_size_t [NUM_PERIPH-1:0] xferSize,
    input  wire logic                        hdTx,
    output logic                             busReq,
    input  wire logic                        busGnt,
    output pdma_pkg::pdma_mem_t              memOut,
    input  wire logic                        memAck,
    input  wire logic [31:0]                 memRdata,
    output pdma_pkg::pdma_hold_t             holdOut,
    input  wire logic [31:0]                 holdRdata,
    output logic [NUM_PERIPH-1:0]            rxEndFlag,
    output logic [NUM_PERIPH-1:0]            txEndFlag,
    output logic [NUM_PERIPH-1:0]            rxBufFull,
    output logic [NUM_PERIPH-1:0]            txBufEmpty
);
    import pdma_pkg::*;

    localparam int NCH = 2 * NUM_PERIPH;
    localparam int HD  = NUM_PERIPH - 1;

    pdma_eng_t              e_q;
    pdma_eng_t              e_d;
    pdma_chan_t             rxSt [NUM_PERIPH];
    pdma_chan_t             txSt [NUM_PERIPH];
    logic [NCH-1:0]         want;
    logic                   anyWant;
    logic [4:0]             pickIdx;
    logic [SEL_W-1:0]       perSel;
    logic [OFS_W-1:0]       ofs;
    logic                   wrHit;
    logic                   setup;
    logic                   regOk;
    logic [31:0]            rdVal;
    logic [SEL_W-1:0]       curPer;
    logic [PTR_W-1:0]       curPtr;
    pdma_size_t             curSize;

    function automatic logic ofsValid(input logic [OFS_W-1:0] o);
        case (o)
            OFS_RX_PTR, OFS_RX_CNT, OFS_TX_PTR, OFS_TX_CNT,
            OFS_RX_NPTR, OFS_RX_NCNT, OFS_TX_NPTR, OFS_TX_NCNT,
            OFS_CTRL, OFS_STAT, OFS_FLAGS: ofsValid = 1'b1;
            default: ofsValid = 1'b0;
        endcase
    endfunction

    function automatic logic chanWant(input pdma_chan_t c);
        chanWant = c.en && c.pend && (c.cnt != CNT_ZERO);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb address decode

    assign perSel = paddr[OFS_W+SEL_W-1:OFS_W];
    assign ofs    = paddr[OFS_W-1:0];
    assign setup  = psel && !penable;
    assign regOk  = ofsValid(ofs) && (perSel < SEL_W'(NUM_PERIPH));
    assign wrHit  = psel && penable && e_q.pready && pwrite && regOk;

    ////////////////////////////////////////////////////////////////////////
    // channel instances, half duplex shares one

    for (genvar p = 0; p < NUM_PERIPH; p++) begin : g_per
        localparam bit IS_HD = (p == HD);
        logic hit;
        logic rxDone;
        logic txDone;
        assign hit = wrHit && (perSel == SEL_W'(p));
        assign rxDone = e_q.done && ((e_q.sel == 5'(p)) ||
                        (IS_HD && (e_q.sel == 5'(NUM_PERIPH + p))));
        assign txDone = e_q.done && (e_q.sel == 5'(NUM_PERIPH + p));

        // half duplex tx view writes land in the same storage
        pdma_dir u_rx (
            .clock  (clock),
            .rstn   (rstn),
            .wrPtr  (hit && (ofs == OFS_RX_PTR ||
                     (IS_HD && ofs == OFS_TX_PTR))),
            .wrCnt  (hit && (ofs == OFS_RX_CNT ||
                     (IS_HD && ofs == OFS_TX_CNT))),
            .wrNptr (hit && (ofs == OFS_RX_NPTR ||
                     (IS_HD && ofs == OFS_TX_NPTR))),
            .wrNcnt (hit && (ofs == OFS_RX_NCNT ||
                     (IS_HD && ofs == OFS_TX_NCNT))),
            .wdata  (pwdata),
            .enSet  (hit && ofs == OFS_CTRL && (pwdata[BIT_RX_EN] ||
                     (IS_HD && pwdata[BIT_TX_EN]))),
            .enClr  (hit && ofs == OFS_CTRL && (pwdata[BIT_RX_DIS] ||
                     (IS_HD && pwdata[BIT_TX_DIS]))),
            .trig   (IS_HD && hdTx ? txReady[p] : rxReady[p]),
            .done   (rxDone),
            .size   (xferSize[p]),
            .st     (rxSt[p])
        );

        if (IS_HD) begin : g_hd
            assign txSt[p] = rxSt[p];
        end else begin : g_fd
            pdma_dir u_tx (
                .clock  (clock),
                .rstn   (rstn),
                .wrPtr  (hit && ofs == OFS_TX_PTR),
                .wrCnt  (hit && ofs == OFS_TX_CNT),
                .wrNptr (hit && ofs == OFS_TX_NPTR),
                .wrNcnt (hit && ofs == OFS_TX_NCNT),
                .wdata  (pwdata),
                .enSet  (hit && ofs == OFS_CTRL && pwdata[BIT_TX_EN]),
                .enClr  (hit && ofs == OFS_CTRL && pwdata[BIT_TX_DIS]),
                .trig   (txReady[p]),
                .done   (txDone),
                .size   (xferSize[p]),
                .st     (txSt[p])
            );
        end

        // nineteen live request slots; half duplex picks one direction
        assign want[p] = chanWant(rxSt[p]) && !(IS_HD && hdTx);
        assign want[NUM_PERIPH+p] = chanWant(txSt[p]) &&
                                    (!IS_HD || hdTx);
        assign rxEndFlag[p]  = rxSt[p].endF;
        assign txEndFlag[p]  = txSt[p].endF;
        assign rxBufFull[p]  = rxSt[p].bufF;
        assign txBufEmpty[p] = txSt[p].bufF;
    end

    pdma_pick #(
        .N  (NCH),
        .IW (5)
    ) u_pick (
        .want (want),
        .any  (anyWant),
        .idx  (pickIdx)
    );

    ////////////////////////////////////////////////////////////////////////
    // register read mux

    always_comb begin
        pdma_chan_t rs;
        pdma_chan_t ts;
        rs    = '0;
        ts    = '0;
        rdVal = '0;
        for (int i = 0; i < NUM_PERIPH; i++) begin
            if (perSel == SEL_W'(i)) begin
                rs = rxSt[i];
                ts = txSt[i];
            end
        end
        case (ofs)
            OFS_RX_PTR:  rdVal = rs.ptr;
            OFS_RX_CNT:  rdVal = {16'h0000, rs.cnt};
            OFS_TX_PTR:  rdVal = ts.ptr;
            OFS_TX_CNT:  rdVal = {16'h0000, ts.cnt};
            OFS_RX_NPTR: rdVal = rs.nptr;
            OFS_RX_NCNT: rdVal = {16'h0000, rs.ncnt};
            OFS_TX_NPTR: rdVal = ts.nptr;
            OFS_TX_NCNT: rdVal = {16'h0000, ts.ncnt};
            OFS_STAT: begin
                rdVal[BIT_RX_EN] = rs.en;
                rdVal[BIT_TX_EN] = ts.en;
            end
            OFS_FLAGS: begin
                rdVal[FLG_RX_END]   = rs.endF;
                rdVal[FLG_TX_END]   = ts.endF;
                rdVal[FLG_RX_FULL]  = rs.bufF;
                rdVal[FLG_TX_EMPTY] = ts.bufF;
            end
            default: rdVal = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // served channel view

    always_comb begin
        curPer  = e_q.isTx ? SEL_W'(e_q.sel - 5'(NUM_PERIPH))
                           : SEL_W'(e_q.sel);
        curPtr  = '0;
        curSize = SZ_BYTE;
        for (int i = 0; i < NUM_PERIPH; i++) begin
            if (curPer == SEL_W'(i)) begin
                curPtr  = e_q.isTx ? txSt[i].ptr : rxSt[i].ptr;
                curSize = xferSize[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer and transfer engine

    always_comb begin
        e_d           = e_q;
        e_d.done      = 1'b0;
        e_d.hold.rd   = 1'b0;
        e_d.hold.wr   = 1'b0;
        e_d.pready    = setup;
        e_d.pslverr   = setup && !regOk;
        e_d.prdata    = (setup && !pwrite && regOk) ? rdVal : '0;
        case (e_q.state)
            ST_IDLE: begin
                if (anyWant) begin
                    e_d.sel    = pickIdx;
                    e_d.isTx   = pickIdx >= 5'(NUM_PERIPH);
                    e_d.busReq = 1'b1;
                    e_d.state  = ST_ASK;
                end
            end
            ST_ASK: begin
                if (busGnt) begin
                    e_d.hold.idx = curPer;
                    if (e_q.isTx) begin
                        e_d.mem.req   = 1'b1;
                        e_d.mem.write = 1'b0;
                        e_d.mem.addr  = curPtr;
                        e_d.mem.size  = curSize;
                        e_d.state     = ST_MEM;
                    end else begin
                        e_d.hold.rd = 1'b1;
                        e_d.state   = ST_HRD;
                    end
                end
            end
            ST_HRD: begin
                e_d.state = ST_HCAP;
            end
            ST_HCAP: begin
                e_d.mem.req   = 1'b1;
                e_d.mem.write = 1'b1;
                e_d.mem.addr  = curPtr;
                e_d.mem.size  = curSize;
                e_d.mem.wdata = holdRdata;
                e_d.state     = ST_MEM;
            end
            ST_MEM: begin
                if (memAck) begin
                    e_d.mem.req = 1'b0;
                    if (e_q.isTx) begin
                        e_d.hold.wr    = 1'b1;
                        e_d.hold.wdata = memRdata;
                        e_d.state      = ST_HWR;
                    end else begin
                        e_d.done  = 1'b1;
                        e_d.state = ST_FIN;
                    end
                end
            end
            ST_HWR: begin
                e_d.done  = 1'b1;
                e_d.state = ST_FIN;
            end
            ST_FIN: begin
                e_d.busReq = 1'b0;
                e_d.state  = ST_IDLE;
            end
            default: begin
                e_d.state  = ST_IDLE;
                e_d.busReq = 1'b0;
                e_d.mem    = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            e_q <= '0;
        end else begin
            e_q <= e_d;
        end
    end

    assign pready  = e_q.pready;
    assign prdata  = e_q.prdata;
    assign pslverr = e_q.pslverr;
    assign busReq  = e_q.busReq;
    assign memOut  = e_q.mem;
    assign holdOut = e_q.hold;

endmodule

// >>> rtl/pdma_pkg.sv
// shared constants and types of the peripheral dma channel block
// assumes one 125 MHz clock, apb register access, memory port to the matrix
package pdma_pkg;

    localparam int NUM_PERIPH = 10;
    localparam int ADDR_W     = 16;
    localparam int OFS_W      = 9;
    localparam int SEL_W      = 4;
    localparam int PTR_W      = 32;
    localparam int CNT_W      = 16;

    // register offsets inside one peripheral window
    localparam logic [OFS_W-1:0] OFS_RX_PTR  = 9'h100;
    localparam logic [OFS_W-1:0] OFS_RX_CNT  = 9'h104;
    localparam logic [OFS_W-1:0] OFS_TX_PTR  = 9'h108;
    localparam logic [OFS_W-1:0] OFS_TX_CNT  = 9'h10C;
    localparam logic [OFS_W-1:0] OFS_RX_NPTR = 9'h110;
    localparam logic [OFS_W-1:0] OFS_RX_NCNT = 9'h114;
    localparam logic [OFS_W-1:0] OFS_TX_NPTR = 9'h118;
    localparam logic [OFS_W-1:0] OFS_TX_NCNT = 9'h11C;
    localparam logic [OFS_W-1:0] OFS_CTRL    = 9'h120;
    localparam logic [OFS_W-1:0] OFS_STAT    = 9'h124;
    localparam logic [OFS_W-1:0] OFS_FLAGS   = 9'h128;

    // control and status bit positions
    localparam int BIT_RX_EN  = 0;
    localparam int BIT_RX_DIS = 1;
    localparam int BIT_TX_EN  = 8;
    localparam int BIT_TX_DIS = 9;
    localparam int FLG_RX_END   = 0;
    localparam int FLG_TX_END   = 1;
    localparam int FLG_RX_FULL  = 2;
    localparam int FLG_TX_EMPTY = 3;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } pdma_size_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ASK  = 3'h1,
        ST_HRD  = 3'h3,
        ST_HCAP = 3'h2,
        ST_MEM  = 3'h6,
        ST_HWR  = 3'h7,
        ST_FIN  = 3'h5
    } pdma_state_t;

    typedef struct packed {
        logic [PTR_W-1:0] ptr;
        logic [PTR_W-1:0] nptr;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] ncnt;
        logic             en;
        logic             pend;
        logic             endF;
        logic             bufF;
    } pdma_chan_t;

    typedef struct packed {
        logic             req;
        logic             write;
        pdma_size_t       size;
        logic [PTR_W-1:0] addr;
        logic [31:0]      wdata;
    } pdma_mem_t;

    typedef struct packed {
        logic             rd;
        logic             wr;
        logic [SEL_W-1:0] idx;
        logic [31:0]      wdata;
    } pdma_hold_t;

    typedef struct packed {
        pdma_state_t      state;
        logic [4:0]       sel;
        logic             isTx;
        logic             done;
        logic             busReq;
        pdma_mem_t        mem;
        pdma_hold_t       hold;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } pdma_eng_t;

    function automatic logic [PTR_W-1:0] ptrStep(input pdma_size_t sz);
        case (sz)
            SZ_BYTE: ptrStep = 32'h0000_0001;
            SZ_HALF: ptrStep = 32'h0000_0002;
            default: ptrStep = 32'h0000_0004;
        endcase
    endfunction

endpackage

// >>> rtl/pdma_dir.sv
// one direction of a channel: pointers, counters, enable, pending, flags
// assumes strobes are one-cycle pulses on the same clock
`timescale 1ns/1ps
module pdma_dir (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             wrPtr,
    input  wire logic             wrCnt,
    input  wire logic             wrNptr,
    input  wire logic             wrNcnt,
    input  wire logic [31:0]      wdata,
    input  wire logic             enSet,
    input  wire logic             enClr,
    input  wire logic             trig,
    input  wire logic             done,
    input  wire pdma_pkg::pdma_size_t size,
    output pdma_pkg::pdma_chan_t  st
);
    import pdma_pkg::*;

    pdma_chan_t st_q;
    pdma_chan_t st_d;
    logic       lastItem;
    logic       cntClr;

    always_comb begin
        st_d     = st_q;
        lastItem = done && (st_q.cnt == CNT_ONE);
        cntClr   = (wrCnt || wrNcnt) && (wdata[CNT_W-1:0] != CNT_ZERO);
        if (done) begin
            st_d.pend = 1'b0;
            st_d.ptr  = st_q.ptr + ptrStep(size);
            st_d.cnt  = st_q.cnt - CNT_ONE;
            if (lastItem && (st_q.ncnt != CNT_ZERO)) begin
                st_d.ptr  = st_q.nptr;
                st_d.cnt  = st_q.ncnt;
                st_d.nptr = '0;
                st_d.ncnt = CNT_ZERO;
            end
        end
        // nonzero count write clears both flags
        if (cntClr) begin
            st_d.endF = 1'b0;
            st_d.bufF = 1'b0;
        end
        if (wrPtr) begin
            st_d.ptr = wdata;
        end
        if (wrCnt) begin
            st_d.cnt = wdata[CNT_W-1:0];
        end
        if (wrNptr) begin
            st_d.nptr = wdata;
        end
        if (wrNcnt) begin
            st_d.ncnt = wdata[CNT_W-1:0];
        end
        // hardware set wins over software clear
        if (lastItem) begin
            st_d.endF = 1'b1;
            if (st_q.ncnt == CNT_ZERO) begin
                st_d.bufF = 1'b1;
            end
        end
        if (trig) begin
            st_d.pend = 1'b1;
        end
        if (enSet) begin
            st_d.en = 1'b1;
        end
        if (enClr) begin
            st_d.en = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign st = st_q;

endmodule

// >>> rtl/pdma_pick.sv
// fixed priority picker over channel requests, lowest index first
// assumes want is stable within the cycle
`timescale 1ns/1ps
module pdma_pick #(
    parameter int N  = 20,
    parameter int IW = 5
) (
    input  wire logic [N-1:0]  want,
    output logic               any,
    output logic [IW-1:0]      idx
);
    always_comb begin
        any = |want;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (want[i]) begin
                idx = IW'(i);
            end
        end
    end

endmodule

// >>> testbench/pdma_channel_assertions.sv
// port checker for the dma channel block
// assumes bind onto pdma_channel, one clock, async low reset
`timescale 1ns/1ps
module pdma_channel_assertions
    import pdma_pkg::*;
#(
    parameter int NUM_PERIPH = 10
) (
    input wire logic                  clock,
    input wire logic                  rstn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire logic                  busReq,
    input wire logic                  busGnt,
    input wire pdma_mem_t             memOut,
    input wire logic                  memAck,
    input wire logic [31:0]           memRdata,
    input wire pdma_hold_t            holdOut,
    input wire logic [NUM_PERIPH-1:0] rxEndFlag,
    input wire logic [NUM_PERIPH-1:0] txEndFlag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence setupS;
        psel && !penable;
    endsequence
    sequence accessS;
        psel && penable && pready;
    endsequence
    sequence txAckS;
        memOut.req && !memOut.write && memAck;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    apb_answer_a: assert property (setupS |=> accessS)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    req_hold_a: assert property (memOut.req && !memAck |=>
        memOut.req && $stable(memOut.addr))
        else $error("memory request dropped");
    req_bus_a: assert property (memOut.req |-> busReq)
        else $error("memory access without bus");
    gnt_first_a: assert property ($rose(memOut.req) |->
        $past(busGnt))
        else $error("access before grant");
    rd_pulse_a: assert property (holdOut.rd |=> !holdOut.rd)
        else $error("holding read too long");
    rx_path_a: assert property (holdOut.rd |->
        ##[1:2] (memOut.req && memOut.write))
        else $error("rx data not written");
    tx_path_a: assert property (txAckS |=> holdOut.wr &&
        holdOut.wdata == $past(memRdata))
        else $error("tx data not forwarded");
    hd_flags_a: assert property (rxEndFlag[NUM_PERIPH-1] ==
        txEndFlag[NUM_PERIPH-1])
        else $error("half duplex flags differ");
endmodule
bind pdma_channel pdma_channel_assertions #(.NUM_PERIPH(NUM_PERIPH)) u_chk (
    .*);

// >>> testbench/pdma_partner.sv
// far side model: matrix grant, memory slave, holding registers
// assumes the dma block clock; stalls drawn at random
`timescale 1ns/1ps
module pdma_partner
    import pdma_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        busReq,
    output logic             busGnt,
    input  wire pdma_mem_t   memOut,
    output logic             memAck,
    output logic [31:0]      memRdata,
    input  wire pdma_hold_t  holdOut,
    output logic [31:0]      holdRdata
);
    // end of transfer interrupt belongs to the peripheral
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busGnt <= 1'b0;
            memAck <= 1'b0;
            memRdata <= 32'h0;
            holdRdata <= 32'h0;
        end else begin
            busGnt <= busReq && (busGnt || $urandom_range(1) == 1);
            memAck <= memOut.req && !memAck && $urandom_range(1) == 1;
            memRdata <= (memOut.req && !memAck) ?
                memOut.addr ^ 32'h5A5A_0000 : ~memRdata;
            holdRdata <= holdOut.rd ?
                32'h0000_00C0 | holdOut.idx : ~holdRdata;
        end
    end
endmodule

// >>> testbench/pdma_channel_tb.sv
// self-checking bench of the dma channel block
// assumes pdma_partner as far side, apb master tasks here
`timescale 1ns/1ps
module pdma_channel_tb;
    import pdma_pkg::*;
    logic              clock = 1'b0;
    logic              rstn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [15:0]       paddr = 16'h0;
    logic [31:0]       pwdata = 32'h0;
    logic              pready, pslverr, busReq, busGnt, memAck, e;
    logic [31:0]       prdata, memRdata, holdRdata, memA, memWd, holdD, r;
    logic [9:0]        rxReady = 10'h0;
    logic [9:0]        txReady = 10'h0;
    logic [9:0]        rxEndFlag, txEndFlag, rxBufFull, txBufEmpty;
    logic              hdTx = 1'b0;
    logic [3:0]        holdI;
    pdma_size_t [9:0]  xferSize = '0;
    pdma_mem_t         memOut;
    pdma_hold_t        holdOut;
    int                errTotal = 0;
    int                checked = 0;
    int                nm = 0;
    always #4 clock = ~clock;
    pdma_channel u_pdma_channel (.*);
    pdma_partner u_pdma_partner (.*);
    always @(posedge clock) begin
        if (memOut.req === 1'b1 && memAck === 1'b1) begin
            memA <= memOut.addr;
            memWd <= memOut.wdata;
            nm <= nm + 1;
        end
        if (holdOut.wr === 1'b1) begin
            holdD <= holdOut.wdata;
            holdI <= holdOut.idx;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] ad(input int p, input logic [8:0] o);
        ad = {3'h0, p[3:0], o};
    endfunction
    function automatic logic [31:0] stepOf(input pdma_size_t s);
        stepOf = (s == SZ_BYTE) ? 32'h1 : (s == SZ_HALF) ? 32'h2 : 32'h4;
    endfunction
    task completeRun;
        if (errTotal == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            errTotal++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask
    task rd(input logic [15:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    task item(input logic rx, input int p, input logic pul);
        int n;
        n = 0;
        if (pul) begin
            @(posedge clock);
            if (rx) rxReady[p] <= 1'b1;
            else txReady[p] <= 1'b1;
            @(posedge clock);
            rxReady <= 10'h0;
            txReady <= 10'h0;
        end
        while (busReq !== 1'b1 && n < 60) begin
            @(posedge clock);
            n++;
        end
        while (busReq === 1'b1 && n < 120) begin
            @(posedge clock);
            n++;
        end
        @(posedge clock);
        chk(n < 120, 1'b1);
    endtask
    initial begin
        #(8 * 20000);
        errTotal++;
        completeRun();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] b, nb;
        int p, q, k;
        void'($urandom(32'h33b4));
        p = $urandom_range(8);
        q = (p + 1) % 9;
        b = {$urandom(), 4'h0};
        nb = {$urandom(), 4'h0};
        for (int i = 0; i < 10; i++)
            xferSize[i] = pdma_size_t'($urandom_range(2));
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(ad(i, OFS_RX_NCNT), 32'h0);
            wr(ad(i, OFS_RX_NCNT), 32'hFFFF_A5C3);
            rd(ad(i, OFS_RX_NCNT), 32'h0000_A5C3);
            wr(ad(i, OFS_RX_NCNT), 32'h0);
        end
        apb(1'b0, {3'h0, 4'hA, OFS_RX_PTR}, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        wr(ad(p, OFS_CTRL), 32'h101);
        rd(ad(p, OFS_STAT), 32'h101);
        wr(ad(p, OFS_CTRL), 32'h202);
        rd(ad(p, OFS_STAT), 32'h0);
        wr(ad(p, OFS_CTRL), 32'h303);
        rd(ad(p, OFS_STAT), 32'h0);
        wr(ad(p, OFS_RX_PTR), b);
        wr(ad(p, OFS_RX_CNT), 32'h2);
        wr(ad(p, OFS_RX_NPTR), nb);
        wr(ad(p, OFS_RX_NCNT), 32'h1);
        wr(ad(p, OFS_CTRL), 32'h1);
        item(1'b1, p, 1'b1);
        chk(memA, b);
        chk(memWd[7:0], 8'hC0 | p);
        rd(ad(p, OFS_RX_CNT), 32'h1);
        item(1'b1, p, 1'b1);
        chk(memA, b + stepOf(xferSize[p]));
        rd(ad(p, OFS_RX_PTR), nb);
        rd(ad(p, OFS_RX_CNT), 32'h1);
        rd(ad(p, OFS_RX_NCNT), 32'h0);
        chk(rxBufFull[p], 1'b0);
        item(1'b1, p, 1'b1);
        chk(memA, nb);
        chk({rxEndFlag[p], rxBufFull[p]}, 2'h3);
        rd(ad(p, OFS_FLAGS), 32'h5);
        k = nm;
        rxReady[p] <= 1'b1;
        @(posedge clock);
        rxReady <= 10'h0;
        repeat (30) @(posedge clock);
        chk(nm, k);
        wr(ad(p, OFS_RX_CNT), 32'h1);
        @(posedge clock);
        chk({rxEndFlag[p], rxBufFull[p]}, 2'h0);
        item(1'b1, p, 1'b0);
        chk(memA, nb + stepOf(xferSize[p]));
        wr(ad(q, OFS_TX_PTR), b);
        wr(ad(q, OFS_TX_CNT), 32'h2);
        wr(ad(q, OFS_CTRL), 32'h100);
        item(1'b0, q, 1'b1);
        chk(holdD, b ^ 32'h5A5A_0000);
        chk(holdI, q);
        wr(ad(q, OFS_TX_PTR), nb);
        item(1'b0, q, 1'b1);
        chk(memA, nb);
        chk({txEndFlag[q], txBufEmpty[q]}, 2'h3);
        wr(ad(q, OFS_TX_NCNT), 32'h3);
        @(posedge clock);
        chk({txEndFlag[q], txBufEmpty[q]}, 2'h0);
        // one direction programmed at a time
        hdTx <= 1'b1;
        wr(ad(9, OFS_TX_PTR), nb);
        rd(ad(9, OFS_RX_PTR), nb);
        wr(ad(9, OFS_TX_CNT), 32'h1);
        wr(ad(9, OFS_CTRL), 32'h100);
        item(1'b0, 9, 1'b1);
        chk(memA, nb);
        chk({rxEndFlag[9], txEndFlag[9]}, 2'h3);
        completeRun();
    end
endmodule
